//--- core/remote_capable_gpio_config.v
// setup registers and pad control for pins 3, 5, 6, 7, 8
`timescale 1ns/1ps
`include "pin_setup_consts.vh"
////////////////////////////////////////////////////////////////////////////
module remote_capable_gpio_config #(
    parameter NPINS = 6
) (
    input  wire       REF_CLK,
    input  wire       RESET,
    input  wire       WR_EN,
    input  wire       RD_EN,
    input  wire [7:0] ADDR,
    input  wire [7:0] WR_DATA,
    output reg  [7:0] RD_DATA,
    output reg        RD_VALID,
    input  wire       SECOND_PORT_SELECT,
    input  wire [NPINS-1:0] REMOTE_LEVEL,
    input  wire [NPINS-1:0] FUNC_LEVEL,
    input  wire [NPINS-1:0] PAD_IN,
    output wire [NPINS-1:0] PAD_OUT,
    output wire [NPINS-1:0] PAD_OE_N,
    output wire [NPINS-1:0] PAD_LEVEL,
    output wire [NPINS-1:0] FUNC_MODE
);
    // pad order: 0 pin3, 1 second_port_pin3, 2 pin5, 3 pin6, 4 pin7, 5 pin8
    localparam       PAD_PIN3        = 0;
    localparam       PAD_SECOND_PIN3 = 1;
    localparam       PAD_PIN5        = 2;
    localparam       PAD_PIN6        = 3;
    localparam       PAD_PIN7        = 4;
    localparam       PAD_PIN8        = 5;
    // an unselected pin3 port is parked tri-stated so it never fights
    localparam [3:0] PARKED          = {2'b00, `MODE_TRISTATE};

    reg  [7:0] io_pin3_setup;
    reg  [7:0] io_pins_5_6_setup;
    reg  [7:0] io_pins_7_8_setup;
    reg  [7:0] next_rd_data;
    wire       hit_pin3;
    wire       hit_pins_5_6;
    wire       hit_pins_7_8;
    wire       write_pin3;
    wire       write_pins_5_6;
    wire       write_pins_7_8;
    wire [3:0] pin3_cfg;
    wire [3:0] pin5_cfg;
    wire [3:0] pin6_cfg;
    wire [3:0] pin7_cfg;
    wire [3:0] pin8_cfg;
    wire [3:0] cfg [0:NPINS-1];

    ////////////////////////////////////////////////////////////////////////
    // address decode
    assign hit_pin3       = (ADDR == `ADDR_PIN3_SETUP);
    assign hit_pins_5_6   = (ADDR == `ADDR_PINS_5_6);
    assign hit_pins_7_8   = (ADDR == `ADDR_PINS_7_8);
    // writes to any other address fall through and change nothing
    assign write_pin3     = WR_EN & hit_pin3;
    assign write_pins_5_6 = WR_EN & hit_pins_5_6;
    assign write_pins_7_8 = WR_EN & hit_pins_7_8;

    ////////////////////////////////////////////////////////////////////////
    // setup registers, one process each so a write touches one byte only
    // the whole pin3 byte is kept, reserved upper nibble included
    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            io_pin3_setup <= `SETUP_RESET;
        end else if (write_pin3) begin
            io_pin3_setup <= WR_DATA;
        end
    end

    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            io_pins_5_6_setup <= `SETUP_RESET;
        end else if (write_pins_5_6) begin
            io_pins_5_6_setup <= WR_DATA;
        end
    end

    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            io_pins_7_8_setup <= `SETUP_RESET;
        end else if (write_pins_7_8) begin
            io_pins_7_8_setup <= WR_DATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read back
    always @* begin
        next_rd_data = 8'h00;
        if (hit_pin3) begin
            next_rd_data = io_pin3_setup;
        end else if (hit_pins_5_6) begin
            next_rd_data = io_pins_5_6_setup;
        end else if (hit_pins_7_8) begin
            next_rd_data = io_pins_7_8_setup;
        end
    end

    // data follows the address every cycle; the strobe only marks it valid
    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            RD_DATA <= 8'h00;
        end else begin
            RD_DATA <= next_rd_data;
        end
    end

    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            RD_VALID <= 1'b0;
        end else begin
            RD_VALID <= RD_EN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field routing
    // upper nibble of the pin3 register reaches no pad
    assign pin3_cfg = io_pin3_setup[3:0];
    assign pin5_cfg = io_pins_5_6_setup[`LO_HALF_BASE +: 4];
    assign pin6_cfg = io_pins_5_6_setup[`HI_HALF_BASE +: 4];
    assign pin7_cfg = io_pins_7_8_setup[`LO_HALF_BASE +: 4];
    assign pin8_cfg = io_pins_7_8_setup[`HI_HALF_BASE +: 4];

    // one pin3 setup, moved between ports; the other port is parked
    assign cfg[PAD_PIN3]        = SECOND_PORT_SELECT ? PARKED
                                                     : pin3_cfg;
    assign cfg[PAD_SECOND_PIN3] = SECOND_PORT_SELECT ? pin3_cfg
                                                     : PARKED;
    assign cfg[PAD_PIN5]        = pin5_cfg;
    assign cfg[PAD_PIN6]        = pin6_cfg;
    assign cfg[PAD_PIN7]        = pin7_cfg;
    assign cfg[PAD_PIN8]        = pin8_cfg;

    ////////////////////////////////////////////////////////////////////////
    // pad steering, one instance per pad
    // pin3 on the first port
    pin_drive u_pin3 (
        .REF_CLK      (REF_CLK),
        .RESET        (RESET),
        .cfg          (cfg[PAD_PIN3]),
        .remote_level (REMOTE_LEVEL[PAD_PIN3]),
        .func_level   (FUNC_LEVEL[PAD_PIN3]),
        .pad_in       (PAD_IN[PAD_PIN3]),
        .pad_out      (PAD_OUT[PAD_PIN3]),
        .pad_oe_n     (PAD_OE_N[PAD_PIN3]),
        .pad_level    (PAD_LEVEL[PAD_PIN3]),
        .func_mode    (FUNC_MODE[PAD_PIN3])
    );

    // pin3 on the second port
    pin_drive u_second_pin3 (
        .REF_CLK      (REF_CLK),
        .RESET        (RESET),
        .cfg          (cfg[PAD_SECOND_PIN3]),
        .remote_level (REMOTE_LEVEL[PAD_SECOND_PIN3]),
        .func_level   (FUNC_LEVEL[PAD_SECOND_PIN3]),
        .pad_in       (PAD_IN[PAD_SECOND_PIN3]),
        .pad_out      (PAD_OUT[PAD_SECOND_PIN3]),
        .pad_oe_n     (PAD_OE_N[PAD_SECOND_PIN3]),
        .pad_level    (PAD_LEVEL[PAD_SECOND_PIN3]),
        .func_mode    (FUNC_MODE[PAD_SECOND_PIN3])
    );

    // pin5, low half of its register
    pin_drive u_pin5 (
        .REF_CLK      (REF_CLK),
        .RESET        (RESET),
        .cfg          (cfg[PAD_PIN5]),
        .remote_level (REMOTE_LEVEL[PAD_PIN5]),
        .func_level   (FUNC_LEVEL[PAD_PIN5]),
        .pad_in       (PAD_IN[PAD_PIN5]),
        .pad_out      (PAD_OUT[PAD_PIN5]),
        .pad_oe_n     (PAD_OE_N[PAD_PIN5]),
        .pad_level    (PAD_LEVEL[PAD_PIN5]),
        .func_mode    (FUNC_MODE[PAD_PIN5])
    );

    // pin6, high half of its register
    pin_drive u_pin6 (
        .REF_CLK      (REF_CLK),
        .RESET        (RESET),
        .cfg          (cfg[PAD_PIN6]),
        .remote_level (REMOTE_LEVEL[PAD_PIN6]),
        .func_level   (FUNC_LEVEL[PAD_PIN6]),
        .pad_in       (PAD_IN[PAD_PIN6]),
        .pad_out      (PAD_OUT[PAD_PIN6]),
        .pad_oe_n     (PAD_OE_N[PAD_PIN6]),
        .pad_level    (PAD_LEVEL[PAD_PIN6]),
        .func_mode    (FUNC_MODE[PAD_PIN6])
    );

    // pin7, low half of its register
    pin_drive u_pin7 (
        .REF_CLK      (REF_CLK),
        .RESET        (RESET),
        .cfg          (cfg[PAD_PIN7]),
        .remote_level (REMOTE_LEVEL[PAD_PIN7]),
        .func_level   (FUNC_LEVEL[PAD_PIN7]),
        .pad_in       (PAD_IN[PAD_PIN7]),
        .pad_out      (PAD_OUT[PAD_PIN7]),
        .pad_oe_n     (PAD_OE_N[PAD_PIN7]),
        .pad_level    (PAD_LEVEL[PAD_PIN7]),
        .func_mode    (FUNC_MODE[PAD_PIN7])
    );

    // pin8, high half of its register
    pin_drive u_pin8 (
        .REF_CLK      (REF_CLK),
        .RESET        (RESET),
        .cfg          (cfg[PAD_PIN8]),
        .remote_level (REMOTE_LEVEL[PAD_PIN8]),
        .func_level   (FUNC_LEVEL[PAD_PIN8]),
        .pad_in       (PAD_IN[PAD_PIN8]),
        .pad_out      (PAD_OUT[PAD_PIN8]),
        .pad_oe_n     (PAD_OE_N[PAD_PIN8]),
        .pad_level    (PAD_LEVEL[PAD_PIN8]),
        .func_mode    (FUNC_MODE[PAD_PIN8])
    );
endmodule

//--- core/pin_setup_consts.vh
// register offsets, field positions and reset values of the pin setup block
`ifndef PIN_SETUP_CONSTS_VH
`define PIN_SETUP_CONSTS_VH
`define ADDR_PIN3_SETUP    8'h1F
`define ADDR_PINS_5_6      8'h20
`define ADDR_PINS_7_8      8'h21
`define SETUP_RESET        8'h00
`define FLD_LEVEL          3
`define FLD_REMOTE         2
`define FLD_DIR            1
`define FLD_EN             0
`define HI_HALF_BASE       4
`define LO_HALF_BASE       0
`define MODE_FUNC_OUT      2'b00
`define MODE_GPIO_OUT      2'b01
`define MODE_TRISTATE      2'b10
`define MODE_GPIO_IN       2'b11
`endif

//--- core/pin_drive.v
// pad steering for one configurable pin
`timescale 1ns/1ps
`include "pin_setup_consts.vh"
module pin_drive (
    input  wire       REF_CLK,
    input  wire       RESET,
    input  wire [3:0] cfg,
    input  wire       remote_level,
    input  wire       func_level,
    input  wire       pad_in,
    output reg        pad_out,
    output reg        pad_oe_n,
    output reg        pad_level,
    output reg        func_mode
);
    reg       next_out;
    reg       next_oe_n;
    reg       next_func;
    wire [1:0] mode;

    assign mode = {cfg[`FLD_DIR], cfg[`FLD_EN]};

    always @* begin
        next_out  = 1'b0;
        next_oe_n = 1'b1;
        next_func = 1'b0;
        if (cfg[`FLD_REMOTE]) begin
            next_out  = remote_level;
            next_oe_n = 1'b0;
        end else begin
            case (mode)
                `MODE_FUNC_OUT: begin
                    next_out  = func_level;
                    next_oe_n = 1'b0;
                    next_func = 1'b1;
                end
                `MODE_GPIO_OUT: begin
                    next_out  = cfg[`FLD_LEVEL];
                    next_oe_n = 1'b0;
                end
                `MODE_TRISTATE: begin
                    next_oe_n = 1'b1;
                end
                `MODE_GPIO_IN: begin
                    next_oe_n = 1'b1;
                end
                default: begin
                    next_oe_n = 1'b1;
                end
            endcase
        end
    end

    // registered so the pad never sees decode glitches
    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            pad_out   <= 1'b0;
            pad_oe_n  <= 1'b1;
            pad_level <= 1'b0;
            func_mode <= 1'b0;
        end else begin
            pad_out   <= next_out;
            pad_oe_n  <= next_oe_n;
            pad_level <= pad_in;
            func_mode <= next_func;
        end
    end
endmodule

//--- testbench/pin_setup_properties.sv
// pad steering assertions
`timescale 1ns/1ps
module pin_setup_properties #(
    parameter NPINS = 6
) (
    input wire             REF_CLK, RESET, WR_EN, SECOND_PORT_SELECT,
    input wire [7:0]       ADDR, WR_DATA,
    input wire [NPINS-1:0] REMOTE_LEVEL, FUNC_LEVEL, PAD_OUT, PAD_OE_N
);
    // one pin3 nibble serves both pin3 ports
    reg [19:0] c;
    always @(posedge REF_CLK or posedge RESET)
        if (RESET) c <= 20'h00000;
        else if (WR_EN && ADDR == 8'h1F) c[3:0] <= WR_DATA[3:0];
        else if (WR_EN && ADDR == 8'h20) c[11:4] <= WR_DATA;
        else if (WR_EN && ADDR == 8'h21) c[19:12] <= WR_DATA;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    a_tri_mode: assert property ($past(c[6:4]) == 3'h2 |->
        PAD_OE_N[2]) else $error("pad driven");
    a_input_mode: assert property ($past(c[18:16]) == 3'h3 |->
        PAD_OE_N[5]) else $error("pad driven");
    a_func_mode: assert property (!$past(RESET) &&
        $past(c[14:12]) == 3'h0 |-> !PAD_OE_N[4] &&
        PAD_OUT[4] == $past(FUNC_LEVEL[4])) else $error("bad func out");
    a_local_drive: assert property ($past(c[10:8]) == 3'h1 |->
        !PAD_OE_N[3] && PAD_OUT[3] == $past(c[11])) else $error("bad out");
    a_remote_drive: assert property ($past(c[18]) |->
        !PAD_OE_N[5] && PAD_OUT[5] == $past(REMOTE_LEVEL[5]))
        else $error("bad remote");
    a_remote_ignored: assert property ($past(c[6:4]) == 3'h1 &&
        $past(c[7] != REMOTE_LEVEL[2]) |-> PAD_OUT[2] == $past(c[7]))
        else $error("remote leaked");
    a_port_steer: assert property ($past(c[2]) |->
        PAD_OE_N[0] == $past(SECOND_PORT_SELECT) && PAD_OE_N[1] != PAD_OE_N[0])
        else $error("bad port");
    a_high_nibble: assert property ($past(c[10]) |->
        PAD_OUT[3] == $past(REMOTE_LEVEL[3])) else $error("bad nibble");
    c_remote: cover property ($past(c[18]));
    c_steer: cover property ($past(c[2] && SECOND_PORT_SELECT));
    c_input: cover property ($past(c[18:16]) == 3'h3);
endmodule
bind remote_capable_gpio_config pin_setup_properties #(
    .NPINS(NPINS)) u_props (.*);

//--- testbench/remote_serializer_model.sv
// remote serializer: pin levels sent over the link
`timescale 1ns/1ps
module remote_serializer_model (
    input  wire       clk,
    output reg  [5:0] level = 6'h00
);
    // fresh random levels each cycle, so a stale sample matches only by chance
    always @(posedge clk) level <= #1 6'($urandom);
endmodule

//--- testbench/remote_capable_gpio_config_tb_top.sv
// pin setup bench
`timescale 1ns/1ps
module remote_capable_gpio_config_tb_top;
    reg        clk = 1'h0, rst = 1'h1, we = 1'h0, re = 1'h0, sel = 1'h0;
    reg  [7:0] ad = 8'h00, wd = 8'h00, m [0:2];
    reg  [5:0] fl = 6'h00, pi = 6'h00, rq = 6'h00;
    reg  [11:0] e;
    wire [7:0] rd;
    wire [5:0] rl, oe, po, pl, fm;
    wire       rv;
    integer    mismatches = 0, checks = 0, i, k;
    always #4 clk = ~clk;
    remote_serializer_model u_remote_serializer_model (.clk(clk), .level(rl));
    remote_capable_gpio_config u_remote_capable_gpio_config (
        .REF_CLK(clk), .RESET(rst), .WR_EN(we), .RD_EN(re), .ADDR(ad),
        .WR_DATA(wd), .RD_DATA(rd), .RD_VALID(rv), .SECOND_PORT_SELECT(sel),
        .REMOTE_LEVEL(rl), .FUNC_LEVEL(fl), .PAD_IN(pi), .PAD_OUT(po),
        .PAD_OE_N(oe), .PAD_LEVEL(pl), .FUNC_MODE(fm));
    // remote levels as the pads sampled them at the last edge
    always @(posedge clk) rq <= rl;
    task chk(input [7:0] s, input [7:0] e);
        checks = checks + 1;
        if (s !== e) begin
            mismatches = mismatches + 1;
            $display("unexpected at %0t: %h vs %h", $time, s, e);
        end
    endtask
    task end_of_test;
        if (mismatches == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task bus(input w, input [7:0] a, input [7:0] d);
        @(posedge clk) #1;
        we = w; re = !w; ad = a; wd = d;
        @(posedge clk) #1;
        we = 1'h0; re = 1'h0;
    endtask
    // upper pin3 nibble left out: it must not steer any pad
    function [5:0] oe_of(input s);
        reg [23:0] c;
        integer j;
        c = {m[2], m[1], m[0][3:0], m[0][3:0]};
        for (j = 0; j < 6; j = j + 1) oe_of[j] = c[4*j+1] && !c[4*j+2];
        oe_of[1:0] = oe_of[1:0] | {!s, s};
    endfunction
    // expected pad values and function flags; unselected pin3 port parked
    function [11:0] drv_of(input s);
        reg [23:0] c;
        reg [3:0]  n;
        integer    j;
        c = {m[2], m[1], s ? m[0][3:0] : 4'h2, s ? 4'h2 : m[0][3:0]};
        for (j = 0; j < 6; j = j + 1) begin
            n = c[4*j +: 4];
            drv_of[j + 6] = n[2] ? rq[j] : n[1:0] == 2'h0 ? fl[j] :
                n[1:0] == 2'h1 && n[3];
            drv_of[j] = n[2:0] == 3'h0;
        end
    endfunction
    initial begin
        i = $urandom(17);
        repeat (6) @(posedge clk);
        #1 rst = 1'h0;
        bus(1'h1, 8'h22, 8'hFF);
        for (k = 0; k < 4; k = k + 1) begin
            if (k < 3) m[k] = 8'h00;
            bus(1'h0, 8'h1F + k[7:0], 8'h00);
            chk(rd, 8'h00);
        end
        for (i = 0; i < 300; i = i + 1) begin
            k = $urandom % 3;
            m[k] = 8'($urandom);
            {sel, fl, pi} = 13'($urandom);
            bus(1'h1, 8'h1F + k[7:0], m[k]);
            bus(1'h0, 8'h1F + k[7:0], 8'h00);
            chk(rd, m[k]);
            chk({rv, 1'h0, oe}, {2'h2, oe_of(sel)});
            e = drv_of(sel);
            chk({2'h0, po}, {2'h0, e[11:6]});
            chk({2'h0, fm}, {2'h0, e[5:0]});
            chk({2'h0, pl}, {2'h0, pi});
        end
        end_of_test;
    end
endmodule
